//--- watchdog_control_flags_tb_top.sv
// Self-checking testbench of the watchdog control block.
`timescale 1ns/1ps
module watchdog_control_flags_tb_top;
  import wdc_pkg::*;
  // ==========================================================================
  // Signals and model state
  localparam logic [11:0] A_KEY = {2'b00, WDC_IDX_KEY, 2'b00};
  localparam logic [11:0] A_CLK = {2'b00, WDC_IDX_CLK, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, WDC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_EIE = {2'b00, WDC_IDX_EIE, 2'b00};
  logic        clock = 0, nrst = 0, ext_rst_n = 1, pfail_n = 1;
  logic [3:0]  wstrb = 4'hf, strb = 4'hf;
  logic [2:0]  prot = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, baud, irq, wrst;
  logic [1:0]  bresp, rresp;
  logic [3:0]  exen;
  logic [7:0]  m = 8'h40, v;
  int          num_errors = 0, compares = 0, cyc = 0, pulses = 0, key = 0, n;

  wdc_top #(.LEN0(10), .LEN1(11), .LEN2(12), .LEN3(6)) DUT (
    .clock(clock), .nrst(nrst), .ext_rst_n(ext_rst_n), .pfail_rst_n(pfail_n),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .uart1_baud_doubler(baud), .watchdog_irq(irq),
    .watchdog_reset_out(wrst), .ext_irq_enable(exen));

  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (wrst === 1'b1)
      pulses++;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // Tasks
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask

  // The model follows the unlock state; only bits 7 and 2 take plain writes.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ul, ad, dd;
    ul = (key == 2);
    ad = 1'b0;
    dd = 1'b0;
    // A write without the low byte lane changes nothing, not even the unlock state.
    if (strb[0])
    begin
      key = (a == A_KEY && d == WDC_KEY_1ST) ? 1
          : (a == A_KEY && d == WDC_KEY_2ND && key == 1) ? 2 : 0;
      if (a == A_CTL)
        m = ul ? (d & 8'hce) : ((m & 8'h4b) | (d & 8'h84));
    end
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= strb;
    prot <= 3'($urandom());
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      ad = ad || (awready === 1'b1);
      dd = dd || (wready === 1'b1);
      if (ad)
        awvalid <= 1'b0;
      if (dd)
        wvalid <= 1'b0;
    end while (!(ad && dd));
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, WDC_RESP_OKAY);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    araddr <= a;
    prot <= 3'($urandom());
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, {24'h00_0000, e});
    chk("rresp", rresp, r);
  endtask

  task unl(input logic [7:0] d);
    wr(A_KEY, WDC_KEY_1ST);
    wr(A_KEY, WDC_KEY_2ND);
    wr(A_CTL, d);
  endtask

  task complete_run();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    void'($urandom(32'h3a45_93dc));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd(A_CTL, m, WDC_RESP_OKAY);
    rd(A_EIE, 8'he0, WDC_RESP_OKAY);
    rd(12'h004, 8'h00, WDC_RESP_SLVERR);
    v = 8'($urandom());
    wr(A_EIE, v);
    rd(A_EIE, {3'h7, v[4:0]}, WDC_RESP_OKAY);
    chk("exen", exen, v[3:0]);
    strb = 4'($urandom()) & 4'he;
    wr(A_EIE, ~v);
    strb = 4'hf;
    rd(A_EIE, {3'h7, v[4:0]}, WDC_RESP_OKAY);
    wr(A_CTL, 8'hff);
    rd(A_CTL, m, WDC_RESP_OKAY);
    chk("baud", baud, 1'b1);
    unl(8'h82);
    rd(A_CTL, m, WDC_RESP_OKAY);
    unl(8'h03);
    wr(A_EIE, 8'h10);
    do @(posedge clock); while (irq !== 1'b1);
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (wrst !== 1'b1);
    chk("delay", 32'(n), 32'd512);
    m = (m & 8'h4a) | 8'h0c;
    rd(A_CTL, m, WDC_RESP_OKAY);
    chk("pulses", 32'(pulses), 32'd1);
    pfail_n <= 1'b0;
    repeat (4) @(posedge clock);
    pfail_n <= 1'b1;
    repeat (3) @(posedge clock);
    m = m & 8'hfb;
    rd(A_CTL, m, WDC_RESP_OKAY);
    unl(8'h01);
    repeat (1100) @(posedge clock);
    m = 8'h08;
    rd(A_CTL, m, WDC_RESP_OKAY);
    chk("pulses", 32'(pulses), 32'd1);
    unl(8'h03);
    wr(A_CLK, 8'hc0);
    // Restarts come every 50 clocks or so; the short length would time out after 64.
    repeat (6)
    begin
      repeat (40) @(posedge clock);
      unl(8'h03);
    end
    rd(A_CTL, m, WDC_RESP_OKAY);
    chk("pulses", 32'(pulses), 32'd1);
    wr(A_CTL, 8'h84);
    ext_rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    ext_rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    m = m & 8'h7e;
    rd(A_CTL, m, WDC_RESP_OKAY);
    chk("baud", baud, 1'b0);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    m = 8'h40;
    rd(A_CTL, m, WDC_RESP_OKAY);
    complete_run();
  end
endmodule // watchdog_control_flags_tb_top

//--- wdc_chk.sv
// Port-level checker of the watchdog control block.
`timescale 1ns/1ps
module wdc_chk (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        ext_rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        uart1_baud_doubler,
  input wire logic        watchdog_irq,
  input wire logic        watchdog_reset_out,
  input wire logic [3:0]  ext_irq_enable
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_wr_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ext_low;
    !ext_rst_n [*4];
  endsequence
  property p_bans;
    s_wr_hs |=> ##1 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_rans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_wlock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wlock: assert property (p_wlock) else $error("write taken while busy");
  property p_rlock;
    s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rlock: assert property (p_rlock) else $error("read busy or wide data");
  property p_pulse;
    watchdog_reset_out |=> !watchdog_reset_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_ext;
    s_ext_low |-> !uart1_baud_doubler && ext_irq_enable == 4'h0;
  endproperty
  a_ext: assert property (p_ext) else $error("external reset kept bits");
  property p_irq;
    watchdog_irq && s_axi_awready && !s_axi_awvalid && !watchdog_reset_out
      && ext_rst_n && $past(ext_rst_n) && $past(ext_rst_n, 2) && $past(ext_rst_n, 3)
      && $past(ext_rst_n, 4) |=> watchdog_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped by itself");
endmodule // wdc_chk

bind wdc_top wdc_chk u_chk (.clock(clock), .nrst(nrst), .ext_rst_n(ext_rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .uart1_baud_doubler(uart1_baud_doubler), .watchdog_irq(watchdog_irq),
  .watchdog_reset_out(watchdog_reset_out), .ext_irq_enable(ext_irq_enable));

//--- wdc_pkg.sv
// Package with register map, field layout and timing counts of the watchdog control block.
package wdc_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] WDC_IDX_KEY  = 8'h00_C7;
  localparam logic [7:0] WDC_IDX_CLK  = 8'h00_8E;
  localparam logic [7:0] WDC_IDX_CTRL = 8'h00_D8;
  localparam logic [7:0] WDC_IDX_EIE  = 8'h00_E8;

  // ==========================================================================
  // Watchdog control field positions.
  localparam int WDC_BIT_BAUD = 7;
  localparam int WDC_BIT_POR  = 6;
  localparam int WDC_BIT_TMO  = 3;
  localparam int WDC_BIT_CAUS = 2;
  localparam int WDC_BIT_EWT  = 1;
  localparam int WDC_BIT_RWT  = 0;

  // Extended interrupt enable fields and the clock-select field position.
  localparam int         WDC_BIT_WATCHDOG_IRQ_ENABLE  = 4;
  localparam logic [2:0] WDC_EIE_RSVD  = 3'h7;
  localparam int         WDC_BIT_CKSEL = 6;

  // ==========================================================================
  // Reset values and unlock key bytes.
  localparam logic [4:0] WDC_EIE_RST  = 5'h00;
  localparam logic [1:0] WDC_CKSEL_RST = 2'h0;
  localparam logic [7:0] WDC_KEY_1ST  = 8'h00_AA;
  localparam logic [7:0] WDC_KEY_2ND  = 8'h00_55;

  // ==========================================================================
  // Timing: reset follows the interrupt by this many clocks.
  localparam int         WDC_RST_DELAY_CLKS = 512;
  localparam int         WDC_DLY_W          = 10;
  localparam logic [9:0] WDC_DLY_LAST       = 10'(WDC_RST_DELAY_CLKS - 1);

  // AXI4-Lite responses.
  localparam logic [1:0] WDC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WDC_RESP_SLVERR = 2'h2;

  // Register select codes.
  typedef enum logic [2:0] {
    WDC_SEL_NONE,
    WDC_SEL_KEY,
    WDC_SEL_CLK,
    WDC_SEL_CTRL,
    WDC_SEL_EIE
  } wdc_sel_t;

  // Stored watchdog control fields.
  typedef struct packed {
    logic baud;
    logic por;
    logic tmo;
    logic cause;
    logic watchdog_reset_enable;
    logic watchdog_restart;
  } wdc_ctrl_t;

endpackage

//--- wdc_top.sv
// Watchdog control, status flags, timed access and extended interrupt enables.
`timescale 1ns/1ps
module wdc_top #(
  parameter int LEN0   = 17,
  parameter int LEN1   = 20,
  parameter int LEN2   = 23,
  parameter int LEN3   = 26,
  parameter int CNT_W  = 26,
  parameter int ADDR_W = 12
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              ext_rst_n,
  input  wire logic              pfail_rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   uart1_baud_doubler,
  output logic                   watchdog_irq,
  output logic                   watchdog_reset_out,
  output logic [3:0]             ext_irq_enable
);
  import wdc_pkg::*;

  // ==========================================================================
  // Address decode.
  function automatic wdc_sel_t decode(input logic [ADDR_W-1:0] a);
    wdc_sel_t s;
    logic [7:0] idx;
    s   = WDC_SEL_NONE;
    idx = a[9:2];
    if ((a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0))
    begin
      if (idx == WDC_IDX_KEY)  s = WDC_SEL_KEY;
      if (idx == WDC_IDX_CLK)  s = WDC_SEL_CLK;
      if (idx == WDC_IDX_CTRL) s = WDC_SEL_CTRL;
      if (idx == WDC_IDX_EIE)  s = WDC_SEL_EIE;
    end
    return s;
  endfunction

  // ==========================================================================
  // Pin synchronisers for the external and power-fail resets.
  logic [1:0] ext_sync_q;
  logic [1:0] pf_sync_q;
  logic       ext_rst;
  logic       pf_rst;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_sync_q <= 2'h3;
      pf_sync_q  <= 2'h3;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], ext_rst_n};
      pf_sync_q  <= {pf_sync_q[0], pfail_rst_n};
    end
  end

  assign ext_rst = !ext_sync_q[1];
  assign pf_rst  = !pf_sync_q[1];

  // ==========================================================================
  // AXI4-Lite write channel: address and data taken in either order.
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  wdc_sel_t          wsel;
  logic              wr_fire;
  logic              wr_en;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wsel          = decode(aw_addr_q);
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en         = wr_fire && w_lane_q && (wsel != WDC_SEL_NONE);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= WDC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wsel == WDC_SEL_NONE) ? WDC_RESP_SLVERR : WDC_RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Timed access unlock: any write with byte lane 0 to a mapped register, other than the key sequence, relocks.
  typedef enum logic [1:0] {
    WDC_TA_LOCKED,
    WDC_TA_HALF,
    WDC_TA_OPEN
  } wdc_ta_t;

  wdc_ta_t ta_q;
  wdc_ta_t ta_d;
  logic    key_wr;
  logic    prot_ok;

  assign key_wr  = wr_en && (wsel == WDC_SEL_KEY);
  assign prot_ok = (ta_q == WDC_TA_OPEN);

  always_comb
  begin
    ta_d = ta_q;
    if (wr_en)
    begin
      unique case (ta_q)
        WDC_TA_LOCKED: ta_d = (key_wr && w_data_q == WDC_KEY_1ST) ? WDC_TA_HALF : WDC_TA_LOCKED;
        WDC_TA_HALF:   ta_d = (key_wr && w_data_q == WDC_KEY_2ND) ? WDC_TA_OPEN : WDC_TA_LOCKED;
        WDC_TA_OPEN:   ta_d = (key_wr && w_data_q == WDC_KEY_1ST) ? WDC_TA_HALF : WDC_TA_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ta_q <= WDC_TA_LOCKED;
    else
      ta_q <= ta_d;
  end

  // ==========================================================================
  // Watchdog counter and reset delay.
  wdc_ctrl_t         ctrl_q;
  logic [4:0]        eie_q;
  logic [1:0]        cksel_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  len_mask;
  logic [WDC_DLY_W-1:0] dly_q;
  logic              dly_act_q;
  logic              wdrst_q;
  logic              ctrl_wr;
  logic              tmo;
  logic              restart;
  logic              dly_done;
  int                len;

  assign ctrl_wr  = wr_en && (wsel == WDC_SEL_CTRL);
  // restart on protected write of one
  assign restart  = ctrl_wr && prot_ok && w_data_q[WDC_BIT_RWT];
  assign len      = (cksel_q == 2'h0) ? LEN0 : (cksel_q == 2'h1) ? LEN1 :
                    (cksel_q == 2'h2) ? LEN2 : LEN3;
  assign len_mask = CNT_W'((64'h1 << len) - 64'h1);
  assign tmo      = ((cnt_q & len_mask) == len_mask) && !restart;
  assign dly_done = dly_act_q && (dly_q == WDC_DLY_LAST) && !restart;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q     <= '0;
      dly_q     <= '0;
      dly_act_q <= 1'b0;
      wdrst_q   <= 1'b0;
    end
    else
    begin
      cnt_q   <= (restart || tmo || ext_rst || wdrst_q) ? '0 : cnt_q + 1'b1;
      dly_q   <= tmo ? '0 : dly_q + 1'b1;
      dly_act_q <= tmo || (dly_act_q && !dly_done && !restart && !ext_rst);
      wdrst_q <= dly_done && ctrl_q.watchdog_reset_enable;
    end
  end

  // ==========================================================================
  // Control, enable and clock-select registers.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q  <= '{baud: 1'b0, por: 1'b1, tmo: 1'b0, cause: 1'b0, watchdog_reset_enable: 1'b0, watchdog_restart: 1'b0};
      eie_q   <= WDC_EIE_RST;
      cksel_q <= WDC_CKSEL_RST;
    end
    else
    begin
      ctrl_q.watchdog_restart <= 1'b0;
      if (ctrl_wr)
      begin
        ctrl_q.baud  <= w_data_q[WDC_BIT_BAUD];
        ctrl_q.cause <= w_data_q[WDC_BIT_CAUS];
        if (prot_ok)
        begin
          ctrl_q.por <= w_data_q[WDC_BIT_POR];
          ctrl_q.tmo <= w_data_q[WDC_BIT_TMO];
          ctrl_q.watchdog_reset_enable <= w_data_q[WDC_BIT_EWT];
          ctrl_q.watchdog_restart <= w_data_q[WDC_BIT_RWT];
        end
      end
      if (tmo)
        ctrl_q.tmo <= 1'b1;
      if (pf_rst)
        ctrl_q.cause <= 1'b0;
      // only when reset enable is set
      if (wdrst_q)
        ctrl_q.cause <= 1'b1;
      // external or watchdog reset clears bits 7 and 0
      if (ext_rst || wdrst_q)
      begin
        ctrl_q.baud <= 1'b0;
        ctrl_q.watchdog_restart  <= 1'b0;
        eie_q       <= WDC_EIE_RST;
        cksel_q     <= WDC_CKSEL_RST;
      end
      else
      begin
        if (wr_en && (wsel == WDC_SEL_EIE))
          eie_q <= w_data_q[4:0];
        if (wr_en && (wsel == WDC_SEL_CLK))
          cksel_q <= w_data_q[WDC_BIT_CKSEL +: 2];
      end
    end
  end

  // ==========================================================================
  // Read channel: one registered answer per request.
  wdc_sel_t   rsel;
  logic [7:0] rd_byte;
  logic [7:0] ctrl_rd;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign rsel = decode(s_axi_araddr);
  assign ctrl_rd = {ctrl_q.baud, ctrl_q.por, 2'h0, ctrl_q.tmo, ctrl_q.cause,
                    ctrl_q.watchdog_reset_enable, ctrl_q.watchdog_restart};
  assign rd_byte = (rsel == WDC_SEL_CTRL) ? ctrl_rd :
                   (rsel == WDC_SEL_EIE)  ? {WDC_EIE_RSVD, eie_q} :
                   (rsel == WDC_SEL_CLK)  ? {cksel_q, 6'h00} : 8'h00;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= WDC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= (rsel == WDC_SEL_NONE) ? WDC_RESP_SLVERR : WDC_RESP_OKAY;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // ==========================================================================
  // Outputs.
  // baud doubler to serial port 1
  assign uart1_baud_doubler = ctrl_q.baud;
  // interrupt gated by enable bit 4
  assign watchdog_irq       = ctrl_q.tmo && eie_q[WDC_BIT_WATCHDOG_IRQ_ENABLE];
  assign watchdog_reset_out = wdrst_q;
  assign ext_irq_enable     = eie_q[3:0];

endmodule // wdc_top
